// ==== verification/testbench.sv ====
// bench for the push-button sequencer with shortened timers
// assumes the processor model and a pulled-up interrupt wire
`timescale 1ns/1ns
`default_nettype none
`include "pb_seq_params.svh"
module testbench;
  localparam int DEB = 10;
  localparam int BLANK = 40;
  localparam int OFFD = 10;
  localparam int INTM = 10;
  localparam int MINOFF = 20;
  // extra off delay stays at its default so that path is exercised as built
  localparam int FORCE = MINOFF + `EXTRA_OFF_DELAY_DEFAULT;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic button_in_n_i = 1'b1;
  logic undervoltage_in_i = 1'b0;
  logic early_warn_in_i = 1'b0;
  logic [1:0] mode = 2'h0;
  wire logic kill_n, power_en_o, irq_out_n_o, irq_out_oe_n_o, early_warn_out_n_o, early_warn_oe_n_o;
  wire logic irq_n = irq_out_oe_n_o ? 1'b1 : irq_out_n_o;
  int errors = 0;
  int samples_checked = 0;
  int lowc = 0;
  int len;
  logic exp_q[$];
  logic en_prev = 1'b0;
  always #25 clk_i = ~clk_i;
  pb_power_sequencer #(.ON_DEBOUNCE_CYC(DEB), .BLANK_CYC(BLANK), .OFF_DEBOUNCE_CYC(OFFD),
    .INT_MIN_CYC(INTM), .MIN_OFF_CYC(MINOFF)) i_dut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .button_in_n_i(button_in_n_i), .kill_n_i(kill_n),
    .undervoltage_in_i(undervoltage_in_i), .early_warn_in_i(early_warn_in_i), .power_en_o(power_en_o),
    .irq_out_n_o(irq_out_n_o), .irq_out_oe_n_o(irq_out_oe_n_o), .early_warn_out_n_o(early_warn_out_n_o),
    .early_warn_oe_n_o(early_warn_oe_n_o));
  up_kill_model i_up (.clk_i(clk_i), .power_on_i(power_en_o), .irq_n_i(irq_n), .mode_i(mode),
    .kill_n_o(kill_n));
  // ************
  // helpers
  // ************
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  // waits on enable (w=0) or the interrupt wire (w=1) and checks the cycle count
  task automatic wait_sig(input bit w, input logic v, input int lo, input int hi, input string msg);
    int n;
    n = 0;
    while ((w ? irq_n : power_en_o) !== v && n <= hi) begin
      step(1);
      n++;
    end
    check(n >= lo && n <= hi, msg);
  endtask
  task automatic power_on(input logic [1:0] m);
    mode = m;
    button_in_n_i = 1'b0;
    exp_q.push_back(1'b1);
    wait_sig(0, 1'b1, DEB, DEB + 5, "turn-on debounce");
    button_in_n_i = 1'b1;
    step(8);
  endtask
  // enable changes are matched against the noted expectations
  always @(negedge clk_i) begin
    if (reset_n_i && power_en_o !== en_prev) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected enable change");
      else check(power_en_o === exp_q.pop_front(), "enable change differs");
    end
    if (reset_n_i && irq_n === 1'b0) lowc++;
    else begin
      if (lowc > 0) check(lowc >= INTM, "interrupt pulse too short");
      lowc = 0;
    end
    en_prev = power_en_o;
  end
  initial begin
    #(50 * 60000);
    errors++;
    finish_test();
  end
  // ************
  // scenarios
  // ************
  initial begin
    void'($urandom(32'h7762));
    step(20);
    reset_n_i = 1'b1;
    check(power_en_o === 1'b0 && irq_out_oe_n_o === 1'b1 && early_warn_oe_n_o === 1'b1, "reset levels");
    repeat (4) begin
      early_warn_in_i = ~early_warn_in_i;
      step(4 + $urandom_range(0, 4));
      check(early_warn_oe_n_o === ~early_warn_in_i && early_warn_out_n_o === 1'b0, "warning pin");
    end
    button_in_n_i = 1'b0;
    step(DEB - 4);
    button_in_n_i = 1'b1;
    step(DEB + 5);
    check(power_en_o === 1'b0, "short press turned power on");
    undervoltage_in_i = 1'b1;
    button_in_n_i = 1'b0;
    step(3 * DEB);
    check(power_en_o === 1'b0, "button not locked out");
    button_in_n_i = 1'b1;
    undervoltage_in_i = 1'b0;
    step(5);
    power_on(2'h1);
    exp_q.push_back(1'b0);
    wait_sig(0, 1'b0, BLANK - 13, BLANK - 2, "blanking abort");
    step(5);
    power_on(2'h0);
    step(BLANK);
    check(power_en_o === 1'b1, "kill high did not keep power");
    button_in_n_i = 1'b0;
    wait_sig(1, 1'b0, OFFD, OFFD + 5, "button interrupt");
    button_in_n_i = 1'b1;
    exp_q.push_back(1'b0);
    wait_sig(0, 1'b0, 10, 20, "kill turned power off");
    step(5);
    power_on(2'h2);
    step(BLANK);
    // held past the minimum pulse, so only the hold keeps the interrupt low here
    len = OFFD + INTM + 6 + $urandom_range(0, 6);
    button_in_n_i = 1'b0;
    step(len);
    check(irq_n === 1'b0, "interrupt not held with button");
    button_in_n_i = 1'b1;
    wait_sig(1, 1'b1, 0, INTM + 5, "interrupt release");
    check(power_en_o === 1'b1, "short press forced power off");
    undervoltage_in_i = 1'b1;
    early_warn_in_i = 1'b1;
    wait_sig(1, 1'b0, OFFD, OFFD + 5, "undervoltage interrupt");
    check(irq_n === 1'b0 && early_warn_oe_n_o === 1'b0, "low battery pair not shown");
    exp_q.push_back(1'b0);
    wait_sig(0, 1'b0, FORCE - OFFD - 3, FORCE + 6, "undervoltage forced off");
    step(2);
    check(irq_n === 1'b1, "interrupt kept after forced off");
    undervoltage_in_i = 1'b0;
    early_warn_in_i = 1'b0;
    step(5);
    power_on(2'h2);
    step(BLANK);
    button_in_n_i = 1'b0;
    exp_q.push_back(1'b0);
    wait_sig(0, 1'b0, FORCE - 2, FORCE + OFFD + 8, "button forced off");
    step(2);
    check(irq_n === 1'b1 && exp_q.size() == 0, "state after forced off");
    button_in_n_i = 1'b1;
    step(5);
    finish_test();
  end
endmodule
`default_nettype wire

// ==== verification/up_kill_model.sv ====
// processor model on the far side: raises kill once powered, answers the interrupt
// assumes an active-high enable and the interrupt wire already resolved by the bench
`timescale 1ns/1ns
`default_nettype none
module up_kill_model #(
  parameter int KILL_WAIT = 12
) (
  input wire logic clk_i,
  input wire logic power_on_i,
  input wire logic irq_n_i,
  input wire logic [1:0] mode_i,
  output logic kill_n_o
);
  // mode 0 answers the interrupt, 1 never starts up, 2 ignores the interrupt
  int up_cnt = 0;
  int irq_cnt = 0;
  initial kill_n_o = 1'b0;
  always @(posedge clk_i) begin
    if (!power_on_i) begin
      // an unpowered processor cannot hold kill high
      up_cnt <= 0;
      irq_cnt <= 0;
      kill_n_o <= 1'b0;
    end else begin
      up_cnt <= up_cnt + 1;
      // once seen, the interrupt is serviced even if its pulse has already ended
      irq_cnt <= (irq_cnt == 0 && irq_n_i) ? 0 : irq_cnt + 1;
      if (mode_i != 2'h1 && up_cnt == 3) kill_n_o <= 1'b1;
      // waits past the minimum pulse so the interrupt width is not cut short
      if (mode_i == 2'h0 && irq_cnt == KILL_WAIT) kill_n_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/pb_power_sequencer.sv ====
// push-button on/off sequencer: debounce, start-up blanking, interrupt and forced off
// pins are asynchronous and pass two flip-flops; comparators are outside this block
`timescale 1ns/1ns
`default_nettype none
`include "pb_seq_params.svh"

module pb_power_sequencer #(
  parameter logic [`TIMER_WIDTH-1:0] EXTRA_OFF_DELAY = `EXTRA_OFF_DELAY_DEFAULT,
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int ON_DEBOUNCE_CYC = `MS_CYCLES(`TURN_ON_DEBOUNCE_MS),
  parameter int BLANK_CYC = `MS_CYCLES(`STARTUP_BLANK_MS),
  parameter int OFF_DEBOUNCE_CYC = `MS_CYCLES(`OFF_DEBOUNCE_MS),
  parameter int INT_MIN_CYC = `MS_CYCLES(`INT_MIN_MS),
  parameter int MIN_OFF_CYC = `MS_CYCLES(`MIN_FORCED_OFF_MS)
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic button_in_n_i,
  input wire logic kill_n_i,
  input wire logic undervoltage_in_i,
  input wire logic early_warn_in_i,
  output logic power_en_o,
  output logic irq_out_n_o,
  output logic irq_out_oe_n_o,
  output logic early_warn_out_n_o,
  output logic early_warn_oe_n_o
);

  localparam int TW = `TIMER_WIDTH;
  localparam logic [TW-1:0] ON_DB = TW'(ON_DEBOUNCE_CYC);
  localparam logic [TW-1:0] BLANK = TW'(BLANK_CYC);
  localparam logic [TW-1:0] OFF_DB = TW'(OFF_DEBOUNCE_CYC);
  localparam logic [TW-1:0] INT_MIN = TW'(INT_MIN_CYC);
  localparam logic [TW-1:0] FORCE_OFF = TW'(MIN_OFF_CYC) + EXTRA_OFF_DELAY;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  pb_seq_pkg::pin_in_t meta_q;
  pb_seq_pkg::pin_in_t pin_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '{1'b1, 1'b1, 1'b0, 1'b0};
      pin_q <= '{1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      meta_q <= '{button_in_n_i, kill_n_i, undervoltage_in_i, early_warn_in_i};
      pin_q <= meta_q;
    end
  end

  wire logic btn_low = !pin_q.button_in_n;
  wire logic kill_low = !pin_q.kill_n;
  wire logic uv = pin_q.undervoltage_in;

  // ************************************************************
  // sequencer state
  // ************************************************************
  pb_seq_pkg::seq_state_t state_q;
  pb_seq_pkg::off_source_t src_q;
  logic [TW-1:0] seq_cnt_q;
  logic [TW-1:0] off_cnt_q;
  logic [TW-1:0] int_cnt_q;
  logic int_active_q;
  logic en_q;

  wire logic on_state = (state_q == pb_seq_pkg::ST_BLANK) || (state_q == pb_seq_pkg::ST_RUN);
  wire logic src_active = (src_q == pb_seq_pkg::SRC_BUTTON) ? btn_low :
                          (src_q == pb_seq_pkg::SRC_UNDERVOLT) ? uv : 1'b0;
  wire logic forced_off = on_state && src_q != pb_seq_pkg::SRC_NONE && src_active &&
                          off_cnt_q >= FORCE_OFF - 1'b1;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= pb_seq_pkg::ST_OFF;
      seq_cnt_q <= '0;
      en_q <= 1'b0;
    end else begin
      unique case (state_q)
        pb_seq_pkg::ST_OFF: begin
          seq_cnt_q <= '0;
          if (btn_low && !uv) begin
            state_q <= pb_seq_pkg::ST_ON_DEBOUNCE;
          end
        end
        pb_seq_pkg::ST_ON_DEBOUNCE: begin
          if (!btn_low || uv) begin
            state_q <= pb_seq_pkg::ST_OFF;
          end else if (seq_cnt_q == ON_DB - 2'd2) begin
            state_q <= pb_seq_pkg::ST_BLANK;
            en_q <= 1'b1;
            seq_cnt_q <= '0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        pb_seq_pkg::ST_BLANK: begin
          if (forced_off) begin
            state_q <= pb_seq_pkg::ST_WAIT_RELEASE;
            en_q <= 1'b0;
          end else if (!kill_low) begin
            state_q <= pb_seq_pkg::ST_RUN;
          end else if (seq_cnt_q == BLANK - 1'b1) begin
            state_q <= pb_seq_pkg::ST_WAIT_RELEASE;
            en_q <= 1'b0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        pb_seq_pkg::ST_RUN: begin
          if (kill_low || forced_off) begin
            state_q <= pb_seq_pkg::ST_WAIT_RELEASE;
            en_q <= 1'b0;
          end
        end
        pb_seq_pkg::ST_WAIT_RELEASE: begin
          // a held button must not immediately re-debounce into a new power-on
          if (!btn_low) begin
            state_q <= pb_seq_pkg::ST_OFF;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // power-down source arbitration and timing
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_q <= pb_seq_pkg::SRC_NONE;
      off_cnt_q <= '0;
    end else if (!on_state || forced_off) begin
      src_q <= pb_seq_pkg::SRC_NONE;
      off_cnt_q <= '0;
    end else if (src_q == pb_seq_pkg::SRC_NONE) begin
      off_cnt_q <= '0;
      // the button can claim the sequence only in the run state, never during start-up blanking
      if (btn_low && state_q == pb_seq_pkg::ST_RUN) begin
        src_q <= pb_seq_pkg::SRC_BUTTON;
      end else if (uv) begin
        src_q <= pb_seq_pkg::SRC_UNDERVOLT;
      end
    end else if (!src_active) begin
      src_q <= pb_seq_pkg::SRC_NONE;
      off_cnt_q <= '0;
    end else begin
      off_cnt_q <= off_cnt_q + 1'b1;
    end
  end

  // ************************************************************
  // interrupt output, open drain
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_active_q <= 1'b0;
      int_cnt_q <= '0;
    end else if (forced_off || !on_state) begin
      int_active_q <= 1'b0;
      int_cnt_q <= '0;
    end else if (!int_active_q) begin
      int_cnt_q <= '0;
      if (src_active && off_cnt_q == OFF_DB - 1'b1) begin
        int_active_q <= 1'b1;
      end
    end else if (int_cnt_q < INT_MIN - 1'b1) begin
      int_cnt_q <= int_cnt_q + 1'b1;
    end else if (!(src_q == pb_seq_pkg::SRC_BUTTON && btn_low)) begin
      int_active_q <= 1'b0;
    end
  end

  // ************************************************************
  // output registers
  // ************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_en_o <= !ENABLE_ACTIVE_HIGH;
      irq_out_n_o <= 1'b0;
      irq_out_oe_n_o <= 1'b1;
      early_warn_out_n_o <= 1'b0;
      early_warn_oe_n_o <= 1'b1;
    end else begin
      power_en_o <= ENABLE_ACTIVE_HIGH ? en_q : !en_q;
      irq_out_oe_n_o <= !int_active_q;
      // comparator output passes through independently of the sequencer
      early_warn_oe_n_o <= !pin_q.early_warn_in;
    end
  end

  wire logic en_out_act = ENABLE_ACTIVE_HIGH ? power_en_o : !power_en_o;

  // ************************************************************
  // assertions
  // ************************************************************
  a_uv_blocks_on: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q == pb_seq_pkg::ST_OFF && uv) |=> !en_q)
    else $error("enable rose during undervoltage");
  a_debounce_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(en_q) |-> $past(state_q) == pb_seq_pkg::ST_ON_DEBOUNCE)
    else $error("enable without debounce");
  a_blank_abort: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q == pb_seq_pkg::ST_BLANK && kill_low && seq_cnt_q == BLANK - 1'b1 && !forced_off) |=> !en_q)
    else $error("blank expiry did not release");
  a_blank_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(en_q) |-> state_q == pb_seq_pkg::ST_BLANK && seq_cnt_q == '0)
    else $error("blank timer not started");
  a_kill_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state_q == pb_seq_pkg::ST_RUN && kill_low) |=> !en_q ##1 !en_out_act)
    else $error("kill did not release enable");
  a_warn_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> early_warn_oe_n_o == !$past(pin_q.early_warn_in))
    else $error("warning output wrong");
  a_force_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    forced_off |=> !en_q && !int_active_q)
    else $error("forced off failed");
  a_int_min: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ($fell(int_active_q) && $past(on_state) && !$past(forced_off)) |-> $past(int_cnt_q) >= INT_MIN - 1'b1)
    else $error("interrupt too short");
  a_polarity: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    1'b1 |=> en_out_act == $past(en_q))
    else $error("enable polarity wrong");

  c_power_on: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(en_q));
  c_run: cover property (@(posedge clk_i) disable iff (!reset_n_i) state_q == pb_seq_pkg::ST_RUN);
  c_irq: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(int_active_q));
  c_forced: cover property (@(posedge clk_i) disable iff (!reset_n_i) forced_off);

endmodule
`default_nettype wire

// ==== verilog/pb_seq_params.svh ====
// timing constants and timer width for the push-button power sequencer
// assumes a 20 MHz clock; included by its bare name
`ifndef PB_SEQ_PARAMS_SVH
`define PB_SEQ_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define TURN_ON_DEBOUNCE_MS 32
`define STARTUP_BLANK_MS 512
`define OFF_DEBOUNCE_MS 32
`define INT_MIN_MS 32
`define MIN_FORCED_OFF_MS 64
`define MS_CYCLES(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)
`define EXTRA_OFF_DELAY_DEFAULT 20000
`define TIMER_WIDTH 24
`endif

// ==== verilog/pb_seq_pkg.sv ====
// types for the push-button power sequencer
// no assumptions beyond a SystemVerilog tool
package pb_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_DEBOUNCE,
    ST_BLANK,
    ST_RUN,
    ST_WAIT_RELEASE
  } seq_state_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BUTTON,
    SRC_UNDERVOLT
  } off_source_t;

  typedef struct packed {
    logic button_in_n;
    logic kill_n;
    logic undervoltage_in;
    logic early_warn_in;
  } pin_in_t;
endpackage
